// >>> include/asu_params.svh
// Constants for the async serial unit transmit path.
// Assumes inclusion by the package and design files by bare name.
`ifndef ASU_PARAMS_SVH
`define ASU_PARAMS_SVH
`define ASU_BAUD_DIV_DEF 16'h0082
`define ASU_BAUD_DIV_W 16
`define ASU_OSC_PER_BUS 3'h4
`define ASU_BITS_8 4'hA
`define ASU_BITS_9 4'hB
`define ASU_BRK_SHORT_8 4'hA
`define ASU_BRK_SHORT_9 4'hB
`define ASU_BRK_LONG_8 4'hB
`define ASU_BRK_LONG_9 4'hC
`define ASU_BRK_STOP_FULL 4'hF
`define ASU_RX_FRAME_W 4
`define ASU_DATA_W 8
`define ASU_SHIFT_W 12
`define ASU_LEVEL_IDLE 1'b1
`endif

// >>> include/asu_pkg.sv
// Types shared by the async serial unit transmit path.
// Assumes asu_params.svh sits in the include path.
`include "asu_params.svh"
package asu_pkg;
    typedef struct packed {
        logic module_enable_bit;
        logic tx_enable;
        logic nine_bit_mode;
        logic send_break_bit;
        logic tx_polarity_invert;
        logic long_break_select;
        logic tx_empty_irq_enable;
        logic tx_done_irq_enable;
        logic baud_source_select;
    } asu_ctrl_s;
    typedef struct packed {
        logic tx_empty_flag;
        logic tx_done_flag;
        logic tx_irq;
    } asu_txstat_s;
    typedef struct packed {
        logic framing_error_flag;
        logic rx_full_flag;
        logic break_seen_flag;
        logic rx_ninth_bit;
        logic [7:0] rx_data;
    } asu_rxstat_s;
    typedef enum logic [3:0] {
        ASU_IDLE = 4'h1,
        ASU_PREAMBLE = 4'h2,
        ASU_DATA = 4'h4,
        ASU_BREAK = 4'h8
    } asu_tx_state_e;
endpackage

// >>> core/asu_baud_gen.sv
// Shared baud tick generator for transmitter and receiver.
// Assumes ref_clk is the oscillator clock; bus clock is a quarter of it.
`include "asu_params.svh"
module asu_baud_gen #(
    parameter logic [`ASU_BAUD_DIV_W-1:0] DIV = `ASU_BAUD_DIV_DEF
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic baud_source_select,
    output logic bit_tick,
    output logic half_tick
);
    logic [2:0] pre;
    logic [`ASU_BAUD_DIV_W-1:0] cnt;
    wire src_tick = baud_source_select ? (pre == 3'h0) : 1'b1;
    wire cnt_end = (cnt == DIV - `ASU_BAUD_DIV_W'(1));
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pre <= 3'h0;
            cnt <= '0;
            bit_tick <= 1'b0;
            half_tick <= 1'b0;
        end else if (clk_en) begin
            // Bus clock source ticks once every four oscillator cycles.
            pre <= (pre == `ASU_OSC_PER_BUS - 3'h1) ? 3'h0 : pre + 3'h1;
            bit_tick <= src_tick && cnt_end;
            // The half tick leads the next bit tick by half a cell in either source mode.
            half_tick <= src_tick && (cnt == (DIV >> 1) - `ASU_BAUD_DIV_W'(1));
            if (src_tick) begin
                cnt <= cnt_end ? '0 : cnt + `ASU_BAUD_DIV_W'(1);
            end
        end
    end
endmodule

// >>> core/asu_break_det.sv
// Break recognition on the receive line, producing a one-cycle break pulse.
// Assumes rxd_sync is already synchronised and bit_tick is mid-bit.
`include "asu_params.svh"
module asu_break_det (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic enable,
    input wire logic bit_tick,
    input wire logic rxd_sync,
    input wire logic nine_bit_mode,
    input wire logic long_break_select,
    input wire logic clear_flags,
    output logic break_pulse
);
    logic [`ASU_RX_FRAME_W-1:0] zeros;
    logic [`ASU_RX_FRAME_W-1:0] need;
    always_comb begin
        unique case ({long_break_select, nine_bit_mode})
            2'b00: need = `ASU_BRK_SHORT_8;
            2'b01: need = `ASU_BRK_SHORT_9;
            2'b10: need = `ASU_BRK_LONG_8;
            default: need = `ASU_BRK_LONG_9;
        endcase
    end
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            zeros <= '0;
            break_pulse <= 1'b0;
        end else if (clk_en) begin
            break_pulse <= 1'b0;
            if (!enable || clear_flags) begin
                zeros <= '0;
            end else if (bit_tick) begin
                if (rxd_sync) begin
                    zeros <= '0;
                end else if (zeros != `ASU_BRK_STOP_FULL) begin
                    zeros <= zeros + `ASU_RX_FRAME_W'(1);
                    break_pulse <= (zeros + `ASU_RX_FRAME_W'(1) == need);
                end
            end
        end
    end
endmodule

// >>> core/asu_tx_path.sv
// Transmit path of the async serial unit, with break recognition on receive.
// Assumes control bits come from CPU-side logic on ref_clk; rxd is a pin.
//
// Summary of operation
// - Characters carry 8 or 9 data bits.
// - Ninth bit comes from tx_ninth_bit.
// - Data buffer holds byte for shift register.
// - Preamble of ones precedes buffered data.
// - Start 0 at LSB, stop 1 at MSB.
// - Empty flag sets on hand-off; interrupt.
// - Line idles high when not sending.
// - Module disable releases the port pins.
// - Send-break loads all-zero break character.
// - Breaks repeat; then at least one 1.
// - Short break: 10 or 11 zeros.
// - Long break: 11 or 12 zeros.
// - Break sets framing, full, break; clears data.
// - Idle character all ones, length from mode.
// - Disabling finishes current character, then idles.
// - Enable re-set mid-frame queues idle character.
// - Break then queued idle, no data pending, halves stop position.
// - Inversion flips every transmitted level.
// - Done flag: all empty, nothing pending.
// - Baud source bus or 4x oscillator.
// - Transmit and receive share baud generator.
`include "asu_params.svh"
module asu_tx_path
    import asu_pkg::*;
#(
    parameter logic [`ASU_BAUD_DIV_W-1:0] BAUD_DIV = `ASU_BAUD_DIV_DEF
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic clk_en,
    input wire asu_pkg::asu_ctrl_s ctrl,
    input wire logic [7:0] serial_data_buffer,
    input wire logic data_write,
    input wire logic tx_ninth_bit,
    input wire logic status_read,
    input wire logic rx_flags_clear,
    input wire logic rxd,
    output logic txd_out,
    output logic txd_oe,
    output logic rxd_owned,
    output asu_pkg::asu_txstat_s tx_status,
    output asu_pkg::asu_rxstat_s rx_status
);
    import asu_pkg::*;

    asu_tx_state_e state;
    asu_tx_state_e next_state;
    logic [`ASU_SHIFT_W-1:0] shreg;
    logic [3:0] bits_left;
    logic [`ASU_DATA_W-1:0] hold;
    logic hold_ninth;
    logic hold_full;
    logic empty_armed;
    logic idle_queued;
    logic te_q;
    logic after_break;
    logic line;
    logic rx_s1;
    logic rx_s2;
    logic bit_tick;
    logic half_tick;
    logic brk_pulse;

    asu_baud_gen #(
        .DIV(BAUD_DIV)
    ) u_baud (
        .ref_clk(ref_clk),
        .srst(srst),
        .clk_en(clk_en),
        .baud_source_select(ctrl.baud_source_select),
        .bit_tick(bit_tick),
        .half_tick(half_tick)
    );

    // Receive side uses the same bit tick as the transmitter.
    asu_break_det u_brk (
        .ref_clk(ref_clk),
        .srst(srst),
        .clk_en(clk_en),
        .enable(ctrl.module_enable_bit),
        .bit_tick(bit_tick),
        .rxd_sync(rx_s2),
        .nine_bit_mode(ctrl.nine_bit_mode),
        .long_break_select(ctrl.long_break_select),
        .clear_flags(rx_flags_clear),
        .break_pulse(brk_pulse)
    );

    wire [3:0] char_len = ctrl.nine_bit_mode ? `ASU_BITS_9 : `ASU_BITS_8;
    wire [3:0] brk_len = ctrl.long_break_select ? char_len + 4'h1 : char_len;
    wire [`ASU_SHIFT_W-1:0] data_frame = ctrl.nine_bit_mode
        ? {2'b11, hold_ninth, hold, 1'b0}
        : {3'b111, hold, 1'b0};
    wire run = ctrl.module_enable_bit;
    wire char_end = (bits_left == 4'h1) && bit_tick;
    // A break followed by a queued idle, with no data pending, cuts its last cell at the half tick.
    wire brk_cut = (state == ASU_BREAK) && (bits_left == 4'h1) && half_tick
        && !ctrl.send_break_bit && idle_queued && !hold_full;
    wire shift_done = char_end || brk_cut;
    wire te_rise = ctrl.tx_enable && !te_q;
    // Starting only on a bit tick keeps the first cell of a character started from idle full length.
    wire start_ok = run && ctrl.tx_enable && bit_tick;
    wire done_now = !hold_full && (state == ASU_IDLE) && !ctrl.send_break_bit && !idle_queued;

    always_comb begin
        next_state = state;
        unique case (state)
            ASU_IDLE: begin
                if (start_ok && ctrl.send_break_bit) begin
                    next_state = ASU_BREAK;
                end else if (start_ok && (hold_full || idle_queued)) begin
                    next_state = ASU_PREAMBLE;
                end
            end
            ASU_PREAMBLE, ASU_DATA, ASU_BREAK: begin
                if (shift_done) begin
                    if (!run || !ctrl.tx_enable) begin
                        next_state = ASU_IDLE;
                    end else if (ctrl.send_break_bit) begin
                        next_state = ASU_BREAK;
                    end else if (state == ASU_BREAK || idle_queued) begin
                        next_state = ASU_PREAMBLE;
                    end else if (hold_full) begin
                        next_state = ASU_DATA;
                    end else begin
                        next_state = ASU_IDLE;
                    end
                end
            end
            default: next_state = ASU_IDLE;
        endcase
    end

    wire enter = (next_state != state) || shift_done;
    wire load_data = enter && (next_state == ASU_DATA);

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state <= ASU_IDLE;
            shreg <= '1;
            bits_left <= 4'h0;
            te_q <= 1'b0;
            after_break <= 1'b0;
        end else if (clk_en) begin
            state <= next_state;
            te_q <= ctrl.tx_enable;
            if (enter) begin
                unique case (next_state)
                    ASU_DATA: begin
                        shreg <= data_frame;
                        bits_left <= char_len;
                    end
                    ASU_BREAK: begin
                        shreg <= '0;
                        bits_left <= brk_len;
                    end
                    ASU_PREAMBLE: begin
                        shreg <= '1;
                        bits_left <= char_len;
                    end
                    default: begin
                        shreg <= '1;
                        bits_left <= 4'h0;
                    end
                endcase
                after_break <= (state == ASU_BREAK);
            end else if (bit_tick && state != ASU_IDLE) begin
                shreg <= {1'b1, shreg[`ASU_SHIFT_W-1:1]};
                bits_left <= bits_left - 4'h1;
            end
        end
    end

    // Holding buffer; the empty flag arms on a status read and clears on a write.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            hold <= '0;
            hold_ninth <= 1'b0;
            hold_full <= 1'b0;
            empty_armed <= 1'b0;
            idle_queued <= 1'b0;
        end else if (clk_en) begin
            if (status_read && !hold_full) begin
                empty_armed <= 1'b1;
            end
            if (data_write) begin
                hold <= serial_data_buffer;
                hold_ninth <= tx_ninth_bit;
            end
            // An unarmed write must not stop a hand-off from emptying the buffer.
            if (data_write && empty_armed) begin
                hold_full <= 1'b1;
                empty_armed <= 1'b0;
            end else if (load_data) begin
                hold_full <= 1'b0;
            end
            if (te_rise && state != ASU_IDLE) begin
                idle_queued <= 1'b1;
            end else if (state == ASU_IDLE && next_state == ASU_PREAMBLE) begin
                idle_queued <= 1'b0;
            end else if (enter && state != ASU_IDLE && next_state == ASU_PREAMBLE) begin
                idle_queued <= 1'b0;
            end else if (!run) begin
                idle_queued <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            line <= `ASU_LEVEL_IDLE;
            txd_out <= `ASU_LEVEL_IDLE;
            txd_oe <= 1'b0;
            rxd_owned <= 1'b0;
            tx_status <= '0;
            rx_s1 <= 1'b1;
            rx_s2 <= 1'b1;
            rx_status <= '0;
        end else if (clk_en) begin
            rx_s1 <= rxd;
            rx_s2 <= rx_s1;
            line <= (state == ASU_IDLE) ? `ASU_LEVEL_IDLE : shreg[0];
            txd_out <= line ^ ctrl.tx_polarity_invert;
            txd_oe <= run;
            rxd_owned <= run;
            tx_status.tx_empty_flag <= !hold_full;
            tx_status.tx_done_flag <= done_now;
            tx_status.tx_irq <= (!hold_full && ctrl.tx_empty_irq_enable)
                || (ctrl.tx_done_irq_enable && done_now);
            if (brk_pulse) begin
                rx_status <= '0;
                rx_status.framing_error_flag <= 1'b1;
                rx_status.rx_full_flag <= 1'b1;
                rx_status.break_seen_flag <= 1'b1;
            end else if (rx_flags_clear) begin
                rx_status.framing_error_flag <= 1'b0;
                rx_status.rx_full_flag <= 1'b0;
                rx_status.break_seen_flag <= 1'b0;
            end
        end
    end
endmodule

// >>> test/asu_tx_path_sva.sv
// Concurrent checks on the ports of the async serial transmit path.
// Assumes it is bound onto asu_tx_path and sees only its ports.
module asu_tx_path_chk
    import asu_pkg::*;
#(
    parameter logic [15:0] BAUD_DIV = 16'h0082
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire asu_pkg::asu_ctrl_s ctrl,
    input wire logic rxd,
    input wire logic txd_out,
    input wire logic txd_oe,
    input wire logic rxd_owned,
    input wire asu_pkg::asu_txstat_s tx_status,
    input wire asu_pkg::asu_rxstat_s rx_status
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    logic [9:0] quiet;
    logic [15:0] zrun;
    // A frame started before the quiet spell may still be shifting, so allow two long frames.
    always_ff @(posedge ref_clk) begin
        if (srst || ctrl.tx_enable || ctrl.send_break_bit || $changed(ctrl.tx_polarity_invert))
            quiet <= 10'h000;
        else if (quiet != 10'h3FF)
            quiet <= quiet + 10'h001;
    end
    always_ff @(posedge ref_clk) begin
        if (srst || rxd)
            zrun <= 16'h0000;
        else if (zrun != 16'hFFFF)
            zrun <= zrun + 16'h0001;
    end
    oe_rise_a: assert property ($rose(txd_oe) |-> $past(ctrl.module_enable_bit))
        else $error("txd_oe rose without module enable");
    oe_drop_a: assert property (!ctrl.module_enable_bit |=> !txd_oe)
        else $error("txd_oe held after module disable");
    pin_release_a: assert property (!ctrl.module_enable_bit |=> !rxd_owned)
        else $error("rxd pin kept after module disable");
    idle_level_a: assert property (
        quiet > 10'd500 |-> txd_out == !ctrl.tx_polarity_invert)
        else $error("line not idle with nothing to send");
    irq_off_a: assert property (
        (!ctrl.tx_empty_irq_enable && !ctrl.tx_done_irq_enable)[*3] |-> !tx_status.tx_irq)
        else $error("interrupt with both enables clear");
    irq_on_a: assert property (
        (ctrl.tx_done_irq_enable && tx_status.tx_done_flag)[*3] |-> tx_status.tx_irq)
        else $error("done flag enabled but no interrupt");
    done_empty_a: assert property (tx_status.tx_done_flag |-> tx_status.tx_empty_flag)
        else $error("done flag set while buffer full");
    brk_flags_a: assert property ($rose(rx_status.break_seen_flag) |->
        rx_status.framing_error_flag && rx_status.rx_full_flag
        && rx_status.rx_data == 8'h00 && !rx_status.rx_ninth_bit)
        else $error("break flag without its side effects");
    brk_len_a: assert property ($rose(rx_status.break_seen_flag) |-> zrun >= 9 * BAUD_DIV)
        else $error("break flagged after too few zeros");
    cover property ($rose(rx_status.break_seen_flag));
    cover property ($fell(txd_out) && txd_oe);
    cover property ($rose(tx_status.tx_done_flag));
endmodule

bind asu_tx_path asu_tx_path_chk #(.BAUD_DIV(BAUD_DIV)) asu_tx_path_chk_inst (
    .ref_clk(ref_clk), .srst(srst), .ctrl(ctrl), .rxd(rxd), .txd_out(txd_out),
    .txd_oe(txd_oe), .rxd_owned(rxd_owned), .tx_status(tx_status), .rx_status(rx_status));

// >>> test/asu_remote_node.sv
// Remote serial node driving the receive line of the unit.
// Assumes bit cells of BIT_CYC ref_clk cycles and a pulsed send request.
module asu_remote_node #(
    parameter int BIT_CYC = 4
) (
    input wire logic ref_clk,
    input wire logic [7:0] zero_cells,
    input wire logic send,
    output logic rxd
);
    timeunit 1ns;
    timeprecision 1ns;
    int left = 0;
    // The line is driven at mark level between bursts, as a real transmitter would.
    always_ff @(posedge ref_clk) begin
        if (send)
            left <= zero_cells * BIT_CYC;
        else if (left > 0)
            left <= left - 1;
    end
    assign rxd = (left == 0);
endmodule

// >>> test/tb_top.sv
// Self-checking bench for the async serial transmit path.
// Assumes the checker binds itself and the remote node drives the receive line.
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import asu_pkg::*;
    localparam int BT = 4;
    logic ref_clk = 0, srst = 1, clk_en = 1, data_write = 0, tx_ninth_bit = 0;
    logic status_read = 0, rx_flags_clear = 0, send = 0, rxd, txd_out, txd_oe, rxd_owned;
    logic [7:0] serial_data_buffer = 8'h00, cells = 8'h00;
    logic drop_te = 0;
    asu_ctrl_s ctrl = '0;
    asu_txstat_s tx_status;
    asu_rxstat_s rx_status;
    int errors = 0, cmp_count = 0, cyc = 0;
    asu_tx_path #(.BAUD_DIV(16'h0004)) asu_tx_path_inst (.ref_clk(ref_clk), .srst(srst),
        .clk_en(clk_en), .ctrl(ctrl), .serial_data_buffer(serial_data_buffer),
        .data_write(data_write), .tx_ninth_bit(tx_ninth_bit), .status_read(status_read),
        .rx_flags_clear(rx_flags_clear), .rxd(rxd), .txd_out(txd_out), .txd_oe(txd_oe),
        .rxd_owned(rxd_owned), .tx_status(tx_status), .rx_status(rx_status));
    asu_remote_node #(.BIT_CYC(BT)) asu_remote_node_inst (.ref_clk(ref_clk),
        .zero_cells(cells), .send(send), .rxd(rxd));
    initial forever #25 ref_clk = ~ref_clk;
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        if (errors == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 8000) begin
            errors++;
            test_done();
        end
    end
    task automatic put(input logic [7:0] d, input logic b8);
        status_read = 1;
        step(1);
        status_read = 0;
        serial_data_buffer = d;
        tx_ninth_bit = b8;
        data_write = 1;
        step(1);
        data_write = 0;
    endtask
    // Samples each cell at its middle, so a few cycles of latency do not matter.
    task automatic frame(input logic [7:0] d, input logic b8, input int bt);
        logic [11:0] got, exp;
        int n, w;
        n = ctrl.nine_bit_mode ? 11 : 10;
        got = '0;
        w = 0;
        exp = ctrl.nine_bit_mode ? {1'b0, 1'b1, b8, d, 1'b0} : {2'b00, 1'b1, d, 1'b0};
        if (ctrl.tx_polarity_invert)
            exp = exp ^ ((12'h001 << n) - 12'h001);
        put(d, b8);
        step(1);
        check(tx_status.tx_empty_flag, 1'b0);
        while (txd_out === !ctrl.tx_polarity_invert && w < 2000) begin
            step(1);
            w++;
        end
        check(w >= (n - 1) * bt, 1'b1);
        // Dropping the enable once the start bit is out must still let the character finish.
        if (drop_te) begin
            ctrl.tx_enable = 0;
        end
        step(bt / 2);
        for (int i = 0; i < n; i++) begin
            got[i] = txd_out;
            step(bt);
        end
        check(got, exp);
        step(2 * bt);
        check(tx_status, 3'b111);
    endtask
    task automatic brk(input logic lb, input logic q);
        int run;
        run = 0;
        ctrl.long_break_select = lb;
        ctrl.send_break_bit = 1;
        while (txd_out === 1'b1 && run < 400) begin
            step(1);
            run++;
        end
        ctrl.send_break_bit = 0;
        run = 0;
        // Toggling the enable inside the last break queues an idle right behind it.
        if (q) begin
            ctrl.tx_enable = 0;
            step(1);
            ctrl.tx_enable = 1;
            step(1);
            run = 2;
        end
        while (txd_out === 1'b0 && run < 400) begin
            step(1);
            run++;
        end
        check(16'(run), 16'((lb ? 11 : 10) * BT - (q ? BT / 2 : 0)));
        step(BT - 1);
        check(txd_out, 1'b1);
    endtask
    initial begin
        step(5);
        srst = 0;
        check({txd_out, txd_oe}, 2'b10);
        ctrl.module_enable_bit = 1;
        ctrl.tx_enable = 1;
        ctrl.tx_done_irq_enable = 1;
        step(2);
        check({txd_oe, rxd_owned}, 2'b11);
        frame(8'hA5, 1'b0, BT);
        ctrl.nine_bit_mode = 1;
        frame(8'h3C, 1'b1, BT);
        ctrl.tx_polarity_invert = 1;
        step(2 * BT);
        check(txd_out, 1'b0);
        frame(8'h5A, 1'b0, BT);
        ctrl.tx_polarity_invert = 0;
        ctrl.nine_bit_mode = 0;
        ctrl.baud_source_select = 1;
        frame(8'hC3, 1'b0, 4 * BT);
        ctrl.baud_source_select = 0;
        brk(1'b0, 1'b0);
        brk(1'b1, 1'b0);
        brk(1'b0, 1'b1);
        // Runs one cell short of and one cell past the break length for short and long breaks in 8-bit mode.
        for (int i = 0; i < 4; i++) begin
            ctrl.long_break_select = i[1];
            rx_flags_clear = 1;
            step(1);
            rx_flags_clear = 0;
            cells = 8'(9 + i[1] + 2 * i[0]);
            send = 1;
            step(1);
            send = 0;
            step(cells * BT + 12);
            check(i[0] ? 16'(rx_status) : 16'(rx_status.break_seen_flag),
                i[0] ? 16'h0E00 : 16'h0000);
        end
        drop_te = 1;
        frame(8'h96, 1'b0, BT);
        step(600);
        check(txd_out, 1'b1);
        ctrl.tx_done_irq_enable = 0;
        step(4);
        check(tx_status.tx_irq, 1'b0);
        ctrl.tx_empty_irq_enable = 1;
        step(2);
        check(tx_status.tx_irq, 1'b1);
        ctrl.module_enable_bit = 0;
        step(2);
        check({txd_oe, rxd_owned}, 2'b00);
        test_done();
    end
endmodule
